/* rtl/ipsc_regs.sv */
// Register bank steering the lamp driver, motion pin and rest states.
// Assumes register accesses arrive already decoded from the serial port,
// and that frame timing supplies lamp pulses, brightness and motion events.
// Operation
// - Force-off set keeps the lamp dark at all times.
// - Force-on set with force-off clear holds the lamp lit continuously, else normal pulsing.
// - Manual select codes 0..3 give 20, 15, 36 and 30 mA, reset 20 mA.
// - Manual select is ignored unless automatic switching is disabled.
// - Interrupt config bit 7 makes the motion pin active high, else low.
// - Interrupt config bit 6 selects edge signalling, else level.
// - In automatic mode brighter surfaces get the low current setting.
// - Automatic high codes 0..3 give 15, 20, 30 and 36 mA, reset 30 mA.
// - Automatic low bit gives 15 mA when zero and 20 mA when one.
// - Automatic bit 0 clear enables automatic switching, set disables.
// - Low above high pins the automatic current at the higher value.
// - Reading the rest register returns the present state in bits 7:6.
// - Writing 0x40, 0x80 or 0xc0 forces rest 1, 2 or 3.
// - Writing 0x00 to the rest register returns to normal operation.
// - Reserved bits have no effect and read as zero.
`timescale 1ns/100ps
module ipsc_regs (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire ipsc_pkg::ipsc_req_t req_i,
  input wire logic lamp_pulse_i,
  input wire logic surface_bright_i,
  input wire logic [1:0] auto_state_i,
  input wire logic motion_event_i,
  input wire logic motion_clr_i,
  output logic [7:0] rdata_o,
  output logic lamp_drive_o,
  output logic [5:0] lamp_ma_o,
  output logic [1:0] force_rest_o,
  output logic [1:0] power_state_o,
  output logic motion_pin_o
);

  ipsc_pkg::ipsc_led_t led_r;
  ipsc_pkg::ipsc_irq_t irq_r;
  ipsc_pkg::ipsc_auto_t auto_r;
  ipsc_pkg::ipsc_power_t rest_r;
  logic pend_r;
  logic [7:0] rdata_r;
  logic lamp_r;
  logic [5:0] ma_r;
  logic pin_r;

  function automatic logic [5:0] manual_ma(input logic [1:0] code);
    logic [5:0] v;
    v = ipsc_pkg::MA_20;
    unique case (code)
      2'h0: v = ipsc_pkg::MA_20;
      2'h1: v = ipsc_pkg::MA_15;
      2'h2: v = ipsc_pkg::MA_36;
      2'h3: v = ipsc_pkg::MA_30;
    endcase
    return v;
  endfunction : manual_ma

  function automatic logic [5:0] high_ma(input logic [1:0] code);
    logic [5:0] v;
    v = ipsc_pkg::MA_15;
    unique case (code)
      2'h0: v = ipsc_pkg::MA_15;
      2'h1: v = ipsc_pkg::MA_20;
      2'h2: v = ipsc_pkg::MA_30;
      2'h3: v = ipsc_pkg::MA_36;
    endcase
    return v;
  endfunction : high_ma

  wire wr_led = req_i.wr && req_i.addr == ipsc_pkg::LED_DRIVE_CONTROL_ADDR;
  wire wr_irq = req_i.wr && req_i.addr == ipsc_pkg::INTERRUPT_PIN_CONFIG_ADDR;
  wire wr_auto = req_i.wr && req_i.addr == ipsc_pkg::AUTO_CURRENT_CONFIG_ADDR;
  wire wr_rest = req_i.wr && req_i.addr == ipsc_pkg::REST_STATE_SELECT_ADDR;

  wire ipsc_pkg::ipsc_led_t led_nxt = {
    req_i.wdata[ipsc_pkg::FORCE_OFF_BIT],
    req_i.wdata[ipsc_pkg::FORCE_ON_BIT],
    req_i.wdata[ipsc_pkg::MANUAL_SEL_LSB +: 2]};
  wire ipsc_pkg::ipsc_irq_t irq_nxt = {
    req_i.wdata[ipsc_pkg::IRQ_POL_BIT],
    req_i.wdata[ipsc_pkg::IRQ_EDGE_BIT]};
  wire ipsc_pkg::ipsc_auto_t auto_nxt = {
    req_i.wdata[ipsc_pkg::AUTO_HI_LSB +: 2],
    req_i.wdata[ipsc_pkg::AUTO_LO_BIT],
    req_i.wdata[ipsc_pkg::AUTO_DIS_BIT]};
  // bits 7:6 name the forced state; 0x00 leaves it.
  wire ipsc_pkg::ipsc_power_t rest_nxt =
    ipsc_pkg::ipsc_power_t'(req_i.wdata[ipsc_pkg::POWER_STATE_LSB +: 2]);

  // A forced state overrides whatever the automatic downshift reports.
  wire [1:0] present_state = (rest_r != ipsc_pkg::IPSC_NORMAL) ?
    rest_r : auto_state_i;

  wire [5:0] lo_ma = auto_r.auto_low_current ? ipsc_pkg::MA_20 :
    ipsc_pkg::MA_15;
  wire [5:0] hi_ma = high_ma(auto_r.auto_high_current);
  // brightness picks, inverted window pins higher.
  wire [5:0] auto_ma = (lo_ma > hi_ma) ? lo_ma :
    (surface_bright_i ? lo_ma : hi_ma);
  // manual field used only when automatic is off.
  wire [5:0] ma_nxt = auto_r.auto_current_disable ?
    manual_ma(led_r.manual_current_select) : auto_ma;

  wire lamp_nxt = led_r.lamp_force_off ? 1'b0 :
    (led_r.lamp_force_on ? 1'b1 : lamp_pulse_i);

  // Set wins over clear so an event in the clearing cycle is kept.
  wire pend_nxt = motion_event_i || (pend_r && !motion_clr_i);
  // edge mode pulses once per event, level mode holds until cleared.
  wire act_nxt = irq_r.irq_edge_mode ? motion_event_i : pend_nxt;
  wire pin_nxt = irq_r.irq_polarity_high ? act_nxt : !act_nxt;

  // read mux, reserved and unmapped bits are zero.
  wire [7:0] rd_mux =
    (req_i.addr == ipsc_pkg::LED_DRIVE_CONTROL_ADDR) ? {4'h0, led_r} :
    (req_i.addr == ipsc_pkg::INTERRUPT_PIN_CONFIG_ADDR) ? {irq_r, 6'h00} :
    (req_i.addr == ipsc_pkg::AUTO_CURRENT_CONFIG_ADDR) ? {4'h0, auto_r} :
    (req_i.addr == ipsc_pkg::REST_STATE_SELECT_ADDR) ?
      {present_state, 6'h00} : 8'h00;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      led_r <= ipsc_pkg::ipsc_led_t'(ipsc_pkg::LED_DRIVE_CONTROL_RST[3:0]);
      irq_r <= ipsc_pkg::ipsc_irq_t'(ipsc_pkg::INTERRUPT_PIN_CONFIG_RST[7:6]);
      auto_r <= ipsc_pkg::ipsc_auto_t'(ipsc_pkg::AUTO_CURRENT_CONFIG_RST[3:0]);
      rest_r <= ipsc_pkg::ipsc_power_t'(ipsc_pkg::REST_STATE_SELECT_RST[7:6]);
    end else begin
      if (wr_led) led_r <= led_nxt;
      if (wr_irq) irq_r <= irq_nxt;
      // bit 0 is the disable flag.
      if (wr_auto) auto_r <= auto_nxt;
      // writing zero clears the forced state.
      if (wr_rest) rest_r <= rest_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_r <= 1'b0;
      pin_r <= 1'b1;
      lamp_r <= 1'b0;
      ma_r <= ipsc_pkg::MA_15;
      rdata_r <= 8'h00;
    end else begin
      pend_r <= pend_nxt;
      pin_r <= pin_nxt;
      lamp_r <= lamp_nxt;
      ma_r <= ma_nxt;
      if (req_i.rd) rdata_r <= rd_mux;
    end
  end

  assign rdata_o = rdata_r;
  assign lamp_drive_o = lamp_r;
  assign lamp_ma_o = ma_r;
  assign force_rest_o = rest_r;
  assign power_state_o = present_state;
  assign motion_pin_o = pin_r;

  property p_force_off;
    @(posedge clk_i) disable iff (sys_rst_i)
    led_r.lamp_force_off |=> !lamp_drive_o;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("Lamp lit while forced off.");

  property p_force_on;
    @(posedge clk_i) disable iff (sys_rst_i)
    (led_r.lamp_force_on && !led_r.lamp_force_off)[*2] |=> lamp_drive_o;
  endproperty
  a_force_on: assert property (p_force_on)
    else $error("Lamp dark while forced on.");

  property p_manual_36;
    @(posedge clk_i) disable iff (sys_rst_i)
    (auto_r.auto_current_disable && led_r.manual_current_select == 2'h2)
      |=> lamp_ma_o == 6'h24;
  endproperty
  a_manual_36: assert property (p_manual_36)
    else $error("Manual code 2 did not give 36 mA.");

  property p_manual_ignored;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!auto_r.auto_current_disable && auto_r.auto_high_current == 2'h0 &&
      !auto_r.auto_low_current) |=> lamp_ma_o == 6'h0f;
  endproperty
  a_manual_ignored: assert property (p_manual_ignored)
    else $error("Manual select leaked into automatic mode.");

  property p_level_low;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!irq_r.irq_polarity_high && !irq_r.irq_edge_mode && pend_nxt)
      |=> !motion_pin_o;
  endproperty
  a_level_low: assert property (p_level_low)
    else $error("Active low level pin not asserted.");

  property p_edge_pulse;
    @(posedge clk_i) disable iff (sys_rst_i)
    (irq_r.irq_edge_mode && irq_r.irq_polarity_high && motion_event_i ##1
      (irq_r.irq_edge_mode && irq_r.irq_polarity_high && !motion_event_i))
      |-> motion_pin_o ##1 !motion_pin_o;
  endproperty
  a_edge_pulse: assert property (p_edge_pulse)
    else $error("Edge mode pin not a single pulse.");

  property p_bright_low;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!auto_r.auto_current_disable && auto_r.auto_high_current == 2'h3 &&
      surface_bright_i) |=> lamp_ma_o == (auto_r.auto_low_current ?
      6'h14 : 6'h0f) || $changed(auto_r);
  endproperty
  a_bright_low: assert property (p_bright_low)
    else $error("Bright surface did not get low current.");

  property p_inverted;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!auto_r.auto_current_disable && auto_r.auto_low_current &&
      auto_r.auto_high_current == 2'h0) |=> lamp_ma_o == 6'h14;
  endproperty
  a_inverted: assert property (p_inverted)
    else $error("Inverted window not pinned at 20 mA.");

  property p_rest_read;
    @(posedge clk_i) disable iff (sys_rst_i)
    (req_i.rd && req_i.addr == 7'h45) |=>
      rdata_o == {$past(present_state), 6'h00};
  endproperty
  a_rest_read: assert property (p_rest_read)
    else $error("Rest register read wrong state.");

  property p_force_rest3;
    @(posedge clk_i) disable iff (sys_rst_i)
    // Reserved low bits may ride along, so only bits 7:6 are matched.
    (req_i.wr && req_i.addr == 7'h45 && req_i.wdata[7:6] == 2'h3)
      |=> force_rest_o == 2'h3 && power_state_o == 2'h3;
  endproperty
  a_force_rest3: assert property (p_force_rest3)
    else $error("Rest 3 not forced.");

  property p_leave_rest;
    @(posedge clk_i) disable iff (sys_rst_i)
    (req_i.wr && req_i.addr == 7'h45 && req_i.wdata == 8'h00)
      |=> force_rest_o == 2'h0;
  endproperty
  a_leave_rest: assert property (p_leave_rest)
    else $error("Forced rest not released.");

  property p_reserved;
    @(posedge clk_i) disable iff (sys_rst_i)
    (req_i.rd && req_i.addr == 7'h40) |=> rdata_o[7:4] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bits read nonzero.");

  property p_high_20;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!auto_r.auto_current_disable && auto_r.auto_high_current == 2'h1 &&
      !surface_bright_i) |=> lamp_ma_o == 6'h14;
  endproperty
  a_high_20: assert property (p_high_20)
    else $error("Automatic high code 1 did not give 20 mA.");

  property p_high_36;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!auto_r.auto_current_disable && auto_r.auto_high_current == 2'h3 &&
      !surface_bright_i) |=> lamp_ma_o == 6'h24;
  endproperty
  a_high_36: assert property (p_high_36)
    else $error("Automatic high code 3 did not give 36 mA.");

  property p_low_15;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!auto_r.auto_current_disable && !auto_r.auto_low_current &&
      surface_bright_i) |=> lamp_ma_o == 6'h0f;
  endproperty
  a_low_15: assert property (p_low_15)
    else $error("Automatic low bit zero did not give 15 mA.");

  property p_low_20;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!auto_r.auto_current_disable && auto_r.auto_low_current &&
      surface_bright_i) |=> lamp_ma_o == 6'h14;
  endproperty
  a_low_20: assert property (p_low_20)
    else $error("Automatic low bit one did not give 20 mA.");

  property p_auto_off;
    @(posedge clk_i) disable iff (sys_rst_i)
    (auto_r.auto_current_disable && led_r.manual_current_select == 2'h0)
      |=> lamp_ma_o == 6'h14;
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("Disabled automatic mode did not use manual select.");

  property p_both_force;
    @(posedge clk_i) disable iff (sys_rst_i)
    (led_r.lamp_force_off && led_r.lamp_force_on && lamp_pulse_i)
      |=> !lamp_drive_o;
  endproperty
  a_both_force: assert property (p_both_force)
    else $error("Force-on beat force-off.");

  property p_level_high;
    @(posedge clk_i) disable iff (sys_rst_i)
    (irq_r.irq_polarity_high && !irq_r.irq_edge_mode && motion_event_i)
      |=> motion_pin_o;
  endproperty
  a_level_high: assert property (p_level_high)
    else $error("Active high level pin not asserted.");

  property p_level_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!irq_r.irq_edge_mode && irq_r.irq_polarity_high && pend_r &&
      !motion_clr_i) |=> motion_pin_o;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("Level mode pin dropped before clear.");

  property p_rsvd_read;
    @(posedge clk_i) disable iff (sys_rst_i)
    (req_i.rd && (req_i.addr == 7'h41 || req_i.addr == 7'h45))
      |=> rdata_o[5:0] == 6'h00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("Reserved low bits read nonzero.");

  property p_force_rest1;
    @(posedge clk_i) disable iff (sys_rst_i)
    (req_i.wr && req_i.addr == 7'h45 && req_i.wdata[7:6] == 2'h1)
      |=> force_rest_o == 2'h1 && power_state_o == 2'h1;
  endproperty
  a_force_rest1: assert property (p_force_rest1)
    else $error("Rest 1 not forced.");

  property p_leave_normal;
    @(posedge clk_i) disable iff (sys_rst_i)
    (req_i.wr && req_i.addr == 7'h45 && req_i.wdata == 8'h00)
      |=> power_state_o == auto_state_i;
  endproperty
  a_leave_normal: assert property (p_leave_normal)
    else $error("Present state not handed back after release.");

  c_force_off: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    led_r.lamp_force_off && led_r.lamp_force_on);
  c_rest2: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    rest_r == ipsc_pkg::IPSC_REST2);
  c_auto_bright: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    !auto_r.auto_current_disable && surface_bright_i ##1 !surface_bright_i);
  c_edge: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_r.irq_edge_mode && motion_event_i);

endmodule : ipsc_regs

/* rtl/ipsc_pkg.sv */
// Package for the illumination and power state register bank.
// Assumes an outside serial port front end that decodes register accesses.
package ipsc_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int MA_W = 6;

  // Register offsets.
  localparam logic [6:0] LED_DRIVE_CONTROL_ADDR = 7'h40;
  localparam logic [6:0] INTERRUPT_PIN_CONFIG_ADDR = 7'h41;
  localparam logic [6:0] AUTO_CURRENT_CONFIG_ADDR = 7'h43;
  localparam logic [6:0] REST_STATE_SELECT_ADDR = 7'h45;

  // Reset values.
  localparam logic [7:0] LED_DRIVE_CONTROL_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_PIN_CONFIG_RST = 8'h40;
  localparam logic [7:0] AUTO_CURRENT_CONFIG_RST = 8'h08;
  localparam logic [7:0] REST_STATE_SELECT_RST = 8'h00;

  // Field positions.
  localparam int FORCE_OFF_BIT = 3;
  localparam int FORCE_ON_BIT = 2;
  localparam int MANUAL_SEL_LSB = 0;
  localparam int IRQ_POL_BIT = 7;
  localparam int IRQ_EDGE_BIT = 6;
  localparam int AUTO_HI_LSB = 2;
  localparam int AUTO_LO_BIT = 1;
  localparam int AUTO_DIS_BIT = 0;
  localparam int POWER_STATE_LSB = 6;

  // Currents in milliamps.
  localparam logic [5:0] MA_15 = 6'h0f;
  localparam logic [5:0] MA_20 = 6'h14;
  localparam logic [5:0] MA_30 = 6'h1e;
  localparam logic [5:0] MA_36 = 6'h24;

  typedef enum logic [1:0] {
    IPSC_NORMAL = 2'b00,
    IPSC_REST1 = 2'b01,
    IPSC_REST2 = 2'b10,
    IPSC_REST3 = 2'b11
  } ipsc_power_t;

  typedef struct packed {
    logic lamp_force_off;
    logic lamp_force_on;
    logic [1:0] manual_current_select;
  } ipsc_led_t;

  typedef struct packed {
    logic irq_polarity_high;
    logic irq_edge_mode;
  } ipsc_irq_t;

  typedef struct packed {
    logic [1:0] auto_high_current;
    logic auto_low_current;
    logic auto_current_disable;
  } ipsc_auto_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ipsc_req_t;

endpackage : ipsc_pkg

/* dv/ipsc_host.sv */
// Host model that issues decoded register writes and reads to the bank.
// Assumes requests launch on the falling edge of the bank clock.
`timescale 1ns/100ps
module ipsc_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output ipsc_pkg::ipsc_req_t req_o
);
  initial begin
    req_o = '0;
  end
  // decoded register write and read tasks.
  // Released fields show inverted values so stale data is never reused.
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : write_reg
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    d = rdata_i;
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
  endtask : read_reg
endmodule : ipsc_host

/* dv/tb_top.sv */
// Self-checking bench for the lamp, motion pin and rest state registers.
// Assumes the host model drives the request struct on falling edges.
`timescale 1ns/100ps
module tb_top;
  localparam logic [6:0] ADR [4] = '{ipsc_pkg::LED_DRIVE_CONTROL_ADDR,
    ipsc_pkg::INTERRUPT_PIN_CONFIG_ADDR, ipsc_pkg::AUTO_CURRENT_CONFIG_ADDR,
    ipsc_pkg::REST_STATE_SELECT_ADDR};
  localparam logic [7:0] RST [4] = '{8'h00, 8'h40, 8'h08, 8'h00};
  localparam logic [5:0] MAN [4] = '{ipsc_pkg::MA_20, ipsc_pkg::MA_15,
    ipsc_pkg::MA_36, ipsc_pkg::MA_30};
  localparam logic [5:0] HI [4] = '{ipsc_pkg::MA_15, ipsc_pkg::MA_20,
    ipsc_pkg::MA_30, ipsc_pkg::MA_36};
  localparam logic [7:0] MCFG [4] = '{8'h40, 8'hc0, 8'h80, 8'h00};
  localparam int MCNT [4] = '{1, 1, 6, 6};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  ipsc_pkg::ipsc_req_t req;
  logic lamp_pulse = 1'b0;
  logic bright = 1'b0;
  logic [1:0] auto_state = 2'h0;
  logic motion_ev = 1'b0;
  logic motion_clr = 1'b0;
  logic [7:0] rdata;
  logic lamp_drive;
  logic [5:0] lamp_ma;
  logic [1:0] force_rest;
  logic [1:0] power_state;
  logic motion_pin;
  logic [7:0] rd;
  int num_errors = 0;
  int tests_run = 0;

  always #2.5 clk_i = ~clk_i;

  ipsc_host host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
  ipsc_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
    .lamp_pulse_i(lamp_pulse), .surface_bright_i(bright),
    .auto_state_i(auto_state), .motion_event_i(motion_ev),
    .motion_clr_i(motion_clr), .rdata_o(rdata), .lamp_drive_o(lamp_drive),
    .lamp_ma_o(lamp_ma), .force_rest_o(force_rest),
    .power_state_o(power_state), .motion_pin_o(motion_pin));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle();
    repeat (3) @(negedge clk_i);
  endtask : settle

  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      host.read_reg(ADR[i], rd);
      check(rd, RST[i]);
    end
    host.read_reg(7'h42, rd);
    check(rd, 8'h00);
    check({2'h0, lamp_ma}, {2'h0, ipsc_pkg::MA_30});
    check({7'h0, motion_pin}, 8'h01);
  endtask : t_reset

  task automatic t_manual();
    host.write_reg(ADR[2], 8'hf1);
    host.read_reg(ADR[2], rd);
    check(rd, 8'h01);
    for (int c = 0; c < 4; c++) begin
      host.write_reg(ADR[0], 8'hf0 | 8'(c));
      settle();
      check({2'h0, lamp_ma}, {2'h0, MAN[c]});
      host.read_reg(ADR[0], rd);
      check(rd, 8'(c));
    end
    // Manual code 3 stays in place while automatic mode takes over.
    host.write_reg(ADR[2], 8'h00);
    settle();
    check({2'h0, lamp_ma}, {2'h0, ipsc_pkg::MA_15});
  endtask : t_manual

  task automatic t_auto();
    logic [5:0] hv;
    logic [5:0] lv;
    logic [5:0] ex;
    for (int v = 0; v < 16; v++) begin
      host.write_reg(ADR[2], 8'(v & 14));
      bright <= v[0];
      settle();
      hv = HI[v[3:2]];
      lv = v[1] ? ipsc_pkg::MA_20 : ipsc_pkg::MA_15;
      ex = (lv > hv) ? lv : (v[0] ? lv : hv);
      check({2'h0, lamp_ma}, {2'h0, ex});
    end
  endtask : t_auto

  task automatic lamp_try(input logic [7:0] cfg, input logic p);
    host.write_reg(ADR[0], cfg);
    lamp_pulse <= p;
    settle();
  endtask : lamp_try

  task automatic t_force();
    lamp_try(8'h08, 1'b1);
    check({7'h0, lamp_drive}, 8'h00);
    lamp_try(8'h04, 1'b0);
    check({7'h0, lamp_drive}, 8'h01);
    lamp_try(8'h0c, 1'b1);
    check({7'h0, lamp_drive}, 8'h00);
    lamp_try(8'h00, 1'b1);
    check({7'h0, lamp_drive}, 8'h01);
    lamp_try(8'h00, 1'b0);
    check({7'h0, lamp_drive}, 8'h00);
  endtask : t_force

  task automatic t_rest();
    auto_state <= 2'h2;
    for (int s = 1; s < 4; s++) begin
      host.write_reg(ADR[3], 8'(s << 6) | 8'h15);
      settle();
      check({6'h0, power_state}, 8'(s));
      host.read_reg(ADR[3], rd);
      check(rd, 8'(s << 6));
    end
    host.write_reg(ADR[3], 8'h00);
    settle();
    check({6'h0, force_rest}, 8'h00);
    check({6'h0, power_state}, 8'h02);
    host.read_reg(ADR[3], rd);
    check(rd, 8'h80);
    host.write_reg(7'h42, 8'hff);
    host.read_reg(7'h42, rd);
    check(rd, 8'h00);
  endtask : t_rest

  task automatic motion_try(input logic [7:0] cfg, output int n);
    host.write_reg(ADR[1], cfg);
    settle();
    n = 0;
    motion_ev <= 1'b1;
    repeat (6) begin
      @(negedge clk_i);
      motion_ev <= 1'b0;
      if (motion_pin === cfg[7]) n++;
    end
    motion_clr <= 1'b1;
    @(negedge clk_i);
    motion_clr <= 1'b0;
    settle();
  endtask : motion_try

  task automatic t_motion();
    int n;
    for (int i = 0; i < 4; i++) begin
      motion_try(MCFG[i], n);
      check(8'(n), 8'(MCNT[i]));
      check({7'h0, motion_pin}, {7'h0, ~MCFG[i][7]});
    end
  endtask : t_motion

  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_manual();
    t_auto();
    t_force();
    t_rest();
    t_motion();
    results();
  end

  // A hung run is counted as a mismatch rather than left spinning.
  initial begin
    #200000;
    num_errors++;
    results();
  end
endmodule : tb_top
